// ===== bench/gdpg_test.sv
// Purpose: self-checking bench for the gated delayed pulse generator
// Assumes: 125 MHz clk, inputs driven 1 ns after the rising edge
// Notes: driver queues expected phase spans, a monitor compares them at done
module gdpg_test import gdpg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, start = 0, tb_sel = 0, pol = 0, ext = 0, gate = 0;
    logic [2:0] mode = 3'h0;
    logic [GDPG_CNT_W-1:0] dly = 32'h0000_0001, wid = 32'h0000_0001;
    logic pout, busy, done;
    int errors = 0, checked = 0, dcnt = 0, wcnt = 0;
    typedef struct {int dlo; int dhi; int wlo; int whi;} gdpg_exp_t;
    gdpg_exp_t expq[$];
    gdpg_exp_t got_e;
    gdpg_top u_dut (.clk(clk), .rst(rst), .start(start), .gate_mode(mode), .timebase_sel(tb_sel),
        .pulse_polarity(pol), .delay_count(dly), .width_count(wid), .external_timebase_input(ext),
        .counter_gate_input(gate), .counter_pulse_output(pout), .busy(busy), .done(done));
    // ----------------------------------------------------------------
    // clock and external timebase (one rising edge every 8 clk)
    // ----------------------------------------------------------------
    always #4 clk = ~clk;
    always begin
        repeat (4) @(posedge clk);
        #1 ext = ~ext;
    end
    // ----------------------------------------------------------------
    // compare tasks and verdict
    // ----------------------------------------------------------------
    task automatic check_span(input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cyc();
        @(posedge clk);
        #1;
    endtask
    // ----------------------------------------------------------------
    // monitor: spans of delay and width level while busy
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            dcnt = 0;
            wcnt = 0;
        end else if (done === 1'b1) begin
            if (expq.size() == 0) check_span(1, 0, 0);
            else begin
                got_e = expq.pop_front();
                check_span(dcnt, got_e.dlo, got_e.dhi);
                check_span(wcnt, got_e.wlo, got_e.whi);
            end
            dcnt = 0;
            wcnt = 0;
        end else if (busy === 1'b1) begin
            if (pout !== pol) wcnt++;
            else dcnt++;
        end
    end
    // ----------------------------------------------------------------
    // driver: one start (plus a refused second one in ungated modes), gate pattern per mode, wait for done
    // ----------------------------------------------------------------
    task automatic fire(input logic [2:0] m, input logic p, input logic t, input int d, input int w);
        gdpg_exp_t e;
        int k;
        mode = m;
        pol = p;
        tb_sel = t;
        dly = GDPG_CNT_W'(d);
        wid = GDPG_CNT_W'(w);
        gate = (m == GDPG_GATE_HIGH || m == GDPG_GATE_RISE);
        e = '{d, d, w, w};
        if (m == GDPG_GATE_HIGH || m == GDPG_GATE_LOW) e = '{d + 3, d + 3, w, w};
        if (m == GDPG_GATE_RISE || m == GDPG_GATE_FALL) e = '{d + 6, d + 10, w, w};
        if (t) e = '{(d - 1) * 8, d * 8 + 8, (w - 1) * 8, w * 8 + 8};
        expq.push_back(e);
        cyc();
        start = 1;
        cyc();
        start = 0;
        for (k = 0; k < 400; k++) begin
            cyc();
            if (done === 1'b1) break;
            if (m == GDPG_GATE_HIGH || m == GDPG_GATE_LOW) begin
                if (k == 2 || k == 5) gate = ~gate; // pause three cycles in delay
            end else if (m == GDPG_GATE_RISE || m == GDPG_GATE_FALL) begin
                if (k == 2 || k >= 5) gate = ~gate; // wrong edge, then trigger, then noise
            end else begin
                gate = 1'($urandom());
                start = (k == 2); // refused while busy
            end
        end
        // a hang counts as a mismatch; the closing verdict reports it
        if (k == 400) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 0, 1);
        end
        // idle after the pulse, no retrigger from gate edges
        repeat (6) begin
            cyc();
            gate = ~gate;
        end
        check_bit(pout, p);
        check_bit(busy, 1'b0);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    logic [2:0] modes[8] = '{3'h0, 3'h5, 3'h6, 3'h7, 3'h1, 3'h2, 3'h3, 3'h4};
    initial begin
        void'($urandom(84));
        repeat (5) @(posedge clk);
        #1 rst = 0;
        foreach (modes[i]) begin
            fire(modes[i], 1'b0, 1'b0, 6 + $urandom % 8, 1 + $urandom % 8);
            fire(modes[i], 1'b1, 1'b0, 6 + $urandom % 8, 1 + $urandom % 8);
        end
        fire(3'h0, 1'b0, 1'b0, 3, 2);
        fire(3'h0, 1'($urandom()), 1'b1, 2 + $urandom % 3, 1 + $urandom % 3);
        repeat (3) cyc();
        print_verdict();
    end
endmodule

// ===== rtl/gdpg_pkg.sv
// Purpose: constants and types for the gated delayed pulse generator
// Assumes: single clock, plain-port configuration, no bus
// Notes: counts are in timebase ticks; widths fixed
//
// What this block does
// - gate mode 0 ignores the gate and starts counting on software start
// - gate mode 1 counts only while the gate is high
// - gate mode 2 counts only while the gate is low
// - gate mode 3 waits for the next gate rising edge after start
// - gate mode 4 waits for the next gate falling edge after start
// - edge modes give exactly one pulse on the first qualifying edge
// - polarity 0: output low during delay, high during width
// - polarity 1: output high during delay, low during width
// - one single pulse per start, never a repeating train
// - delay phase lasts the programmed number of timebase ticks
// - width phase lasts a separately programmed number of ticks
// - timebase 0 uses the internal clock, 1 the external source pin
package gdpg_pkg;
    // ----------------------------------------------------------------
    // widths and encodings
    // ----------------------------------------------------------------
    localparam int GDPG_CNT_W = 32;
    localparam logic [2:0] GDPG_GATE_NONE = 3'h0;
    localparam logic [2:0] GDPG_GATE_HIGH = 3'h1;
    localparam logic [2:0] GDPG_GATE_LOW = 3'h2;
    localparam logic [2:0] GDPG_GATE_RISE = 3'h3;
    localparam logic [2:0] GDPG_GATE_FALL = 3'h4;
    localparam logic GDPG_TB_INTERNAL = 1'h0;
    localparam logic GDPG_TB_EXTERNAL = 1'h1;
    localparam logic GDPG_POL_HIGH_PULSE = 1'h0;
    localparam logic [GDPG_CNT_W-1:0] GDPG_CNT_ZERO = 32'h0000_0000;
    localparam logic [GDPG_CNT_W-1:0] GDPG_CNT_ONE = 32'h0000_0001;

    typedef enum logic [1:0] {
        GDPG_IDLE = 2'b00,
        GDPG_ARMED = 2'b01,
        GDPG_DELAY = 2'b10,
        GDPG_WIDTH = 2'b11
    } gdpg_state_t;
endpackage

// ===== rtl/gdpg_tick.sv
// Purpose: timebase tick and gate edge detection
// Assumes: inputs synchronous to clk
// Notes: external tick is one cycle per rising edge of the source pin
module gdpg_tick import gdpg_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic timebase_sel,
    input wire logic external_timebase_input,
    input wire logic counter_gate_input,
    output logic tick,
    output logic gate_rise,
    output logic gate_fall
);
    logic src_q, src_d, gate_q, gate_d;

    // -----------------------------------------------------------------
    // previous sample registers
    // -----------------------------------------------------------------
    always_comb begin
        src_d = external_timebase_input;
        gate_d = counter_gate_input;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src_q <= 1'b0;
            gate_q <= 1'b0;
        end else begin
            src_q <= src_d;
            gate_q <= gate_d;
        end
    end

    // tick select and edge flags
    always_comb begin
        if (timebase_sel == GDPG_TB_EXTERNAL) begin
            tick = external_timebase_input & ~src_q;
        end else begin
            tick = 1'b1;
        end
        gate_rise = counter_gate_input & ~gate_q;
        gate_fall = ~counter_gate_input & gate_q;
    end
endmodule

// ===== rtl/gdpg_top.sv
// Purpose: one-shot delayed pulse generator with gating and polarity
// Assumes: config held stable while busy; delay/width >= 1 tick
// Notes: zero counts are treated as one tick
module gdpg_top import gdpg_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [2:0] gate_mode,
    input wire logic timebase_sel,
    input wire logic pulse_polarity,
    input wire logic [GDPG_CNT_W-1:0] delay_count,
    input wire logic [GDPG_CNT_W-1:0] width_count,
    input wire logic external_timebase_input,
    input wire logic counter_gate_input,
    output logic counter_pulse_output,
    output logic busy,
    output logic done
);
    gdpg_state_t state_q, state_d;
    logic [GDPG_CNT_W-1:0] cnt_q, cnt_d;
    logic out_q, out_d, done_q, done_d;
    logic tick, gate_rise, gate_fall, run;

    // clamp zero to one tick
    function automatic logic [GDPG_CNT_W-1:0] gdpg_len(input logic [GDPG_CNT_W-1:0] v);
        gdpg_len = (v == GDPG_CNT_ZERO) ? GDPG_CNT_ONE : v;
    endfunction

    gdpg_tick u_tick (
        .clk(clk),
        .rst(rst),
        .timebase_sel(timebase_sel),
        .external_timebase_input(external_timebase_input),
        .counter_gate_input(counter_gate_input),
        .tick(tick),
        .gate_rise(gate_rise),
        .gate_fall(gate_fall)
    );

    // -----------------------------------------------------------------
    // gating qualifier
    // -----------------------------------------------------------------
    always_comb begin
        if (gate_mode == GDPG_GATE_HIGH) begin
            run = counter_gate_input;
        end else if (gate_mode == GDPG_GATE_LOW) begin
            run = ~counter_gate_input;
        end else begin
            run = 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // sequencer
    // -----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        out_d = out_q;
        done_d = 1'b0;
        case (state_q)
            GDPG_IDLE: begin
                out_d = pulse_polarity; // delay level while idle
                if (start) begin
                    cnt_d = gdpg_len(delay_count);
                    if (gate_mode == GDPG_GATE_RISE || gate_mode == GDPG_GATE_FALL) begin
                        state_d = GDPG_ARMED;
                    end else begin
                        state_d = GDPG_DELAY;
                    end
                end
            end
            GDPG_ARMED: begin
                if ((gate_mode == GDPG_GATE_RISE && gate_rise) ||
                    (gate_mode == GDPG_GATE_FALL && gate_fall)) begin
                    state_d = GDPG_DELAY;
                end
            end
            GDPG_DELAY: begin
                if (tick && run) begin
                    if (cnt_q == GDPG_CNT_ONE) begin
                        cnt_d = gdpg_len(width_count);
                        out_d = ~pulse_polarity;
                        state_d = GDPG_WIDTH;
                    end else begin
                        cnt_d = cnt_q - GDPG_CNT_ONE;
                    end
                end
            end
            GDPG_WIDTH: begin
                if (tick && run) begin
                    if (cnt_q == GDPG_CNT_ONE) begin
                        out_d = pulse_polarity;
                        done_d = 1'b1;
                        state_d = GDPG_IDLE; // no rearm
                    end else begin
                        cnt_d = cnt_q - GDPG_CNT_ONE;
                    end
                end
            end
            default: begin
                state_d = GDPG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= GDPG_IDLE;
            cnt_q <= GDPG_CNT_ZERO;
            out_q <= GDPG_POL_HIGH_PULSE;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
            done_q <= done_d;
        end
    end

    assign counter_pulse_output = out_q;
    assign busy = (state_q != GDPG_IDLE);
    assign done = done_q;

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    property p_mode0_start;
        @(posedge clk) disable iff (rst)
        (state_q == GDPG_IDLE && start && gate_mode == GDPG_GATE_NONE) |=> state_q == GDPG_DELAY;
    endproperty
    a_mode0_start: assert property (p_mode0_start) else $error("mode 0 start did not begin delay");

    property p_gate_high_hold;
        @(posedge clk) disable iff (rst)
        (state_q == GDPG_DELAY && gate_mode == GDPG_GATE_HIGH && !counter_gate_input) |=> $stable(cnt_q);
    endproperty
    a_gate_high_hold: assert property (p_gate_high_hold) else $error("counted while gate low");

    property p_gate_low_hold;
        @(posedge clk) disable iff (rst)
        (state_q == GDPG_DELAY && gate_mode == GDPG_GATE_LOW && counter_gate_input) |=> $stable(cnt_q);
    endproperty
    a_gate_low_hold: assert property (p_gate_low_hold) else $error("counted while gate high");

    property p_rise_wait;
        @(posedge clk) disable iff (rst)
        (state_q == GDPG_ARMED && gate_mode == GDPG_GATE_RISE && !gate_rise) |=> state_q == GDPG_ARMED;
    endproperty
    a_rise_wait: assert property (p_rise_wait) else $error("left armed without rising edge");

    property p_fall_go;
        @(posedge clk) disable iff (rst)
        (state_q == GDPG_ARMED && gate_mode == GDPG_GATE_FALL && gate_fall) |=> state_q == GDPG_DELAY;
    endproperty
    a_fall_go: assert property (p_fall_go) else $error("falling edge did not start delay");

    property p_pol_delay;
        @(posedge clk) disable iff (rst)
        (state_q == GDPG_DELAY) |-> counter_pulse_output == pulse_polarity;
    endproperty
    a_pol_delay: assert property (p_pol_delay) else $error("wrong delay level");

    property p_pol_width;
        @(posedge clk) disable iff (rst)
        (state_q == GDPG_WIDTH) |-> counter_pulse_output == ~pulse_polarity;
    endproperty
    a_pol_width: assert property (p_pol_width) else $error("wrong width level");

    property p_end_idle;
        @(posedge clk) disable iff (rst)
        done |-> (state_q == GDPG_IDLE && counter_pulse_output == pulse_polarity);
    endproperty
    a_end_idle: assert property (p_end_idle) else $error("not idle after pulse");

    property p_single;
        @(posedge clk) disable iff (rst)
        (done && !start) |=> state_q == GDPG_IDLE;
    endproperty
    a_single: assert property (p_single) else $error("pulse repeated without start");

    property p_int_delay3;
        @(posedge clk) disable iff (rst)
        (state_q == GDPG_IDLE && start && gate_mode == GDPG_GATE_NONE && timebase_sel == GDPG_TB_INTERNAL
         && delay_count == 32'h0000_0003) |=> (state_q == GDPG_DELAY) [*3] ##1 state_q == GDPG_WIDTH;
    endproperty
    a_int_delay3: assert property (p_int_delay3) else $error("delay of three ticks wrong");

    property p_rise_go;
        @(posedge clk) disable iff (rst)
        (state_q == GDPG_ARMED && gate_mode == GDPG_GATE_RISE && gate_rise) |=> state_q == GDPG_DELAY;
    endproperty
    a_rise_go: assert property (p_rise_go) else $error("rising edge did not start delay");

    property p_fall_wait;
        @(posedge clk) disable iff (rst)
        (state_q == GDPG_ARMED && gate_mode == GDPG_GATE_FALL && !gate_fall) |=> state_q == GDPG_ARMED;
    endproperty
    a_fall_wait: assert property (p_fall_wait) else $error("left armed without falling edge");

    // idle never leaves without a start, so gate edges cannot retrigger
    property p_idle_stay;
        @(posedge clk) disable iff (rst)
        (state_q == GDPG_IDLE && !start) |=> state_q == GDPG_IDLE;
    endproperty
    a_idle_stay: assert property (p_idle_stay) else $error("left idle without start");

    // external timebase: no rising source edge means no count
    property p_ext_hold;
        @(posedge clk) disable iff (rst)
        (state_q == GDPG_DELAY && timebase_sel == GDPG_TB_EXTERNAL
         && !(external_timebase_input && !$past(external_timebase_input))) |=> $stable(cnt_q);
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("counted without source edge");

    property p_width_end;
        @(posedge clk) disable iff (rst)
        (state_q == GDPG_WIDTH && cnt_q == GDPG_CNT_ONE && tick && run) |=> (done && state_q == GDPG_IDLE);
    endproperty
    a_width_end: assert property (p_width_end) else $error("width did not end on last tick");

    // last delay tick loads the width; two internal ticks of width
    property p_int_width2;
        @(posedge clk) disable iff (rst)
        (state_q == GDPG_DELAY && cnt_q == GDPG_CNT_ONE && gate_mode == GDPG_GATE_NONE
         && timebase_sel == GDPG_TB_INTERNAL && width_count == 32'h0000_0002)
        |=> (state_q == GDPG_WIDTH) [*2] ##1 state_q == GDPG_IDLE;
    endproperty
    a_int_width2: assert property (p_int_width2) else $error("width of two ticks wrong");

    c_pulse: cover property (@(posedge clk) disable iff (rst) done);
    c_rise: cover property (@(posedge clk) disable iff (rst) state_q == GDPG_ARMED && gate_rise);
    c_ext: cover property (@(posedge clk) disable iff (rst) state_q == GDPG_WIDTH && timebase_sel);
    c_fall: cover property (@(posedge clk) disable iff (rst) state_q == GDPG_ARMED && gate_fall);
    c_pause: cover property (@(posedge clk) disable iff (rst)
        state_q == GDPG_DELAY && gate_mode == GDPG_GATE_HIGH && !counter_gate_input);
endmodule
